// file: scd_clock_divider.v
`include "scd_regs.vh"
`default_nettype none
module scd_clock_divider #(
	parameter [15:0] WAKE_WAIT = `SCD_WAKE_WAIT
) (
	// Clock, reset, enable
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [17:2] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// Oscillator and chip state
	input  wire        osc_i,
	input  wire        hw_standby_i,
	input  wire        sw_standby_i,
	input  wire        clk_out_mode_i,
	// System clock and derived clocks
	output wire        sysclk_o,
	output wire        sys_tick_o,
	output wire [11:0] presc_tick_o,
	output wire        wake_ready_o,
	// System clock pin
	output wire        sysclk_pin_o,
	output wire        sysclk_pin_oe_n_o
);
	// =============================================
	// Declarations

	// Register state
	reg  [1:0]  ratio_q;     // Ratio select field
	reg         clock_pin_stop_q;     // Clock pin stop
	reg         ack_q;       // Bus acknowledge
	reg  [31:0] dat_q;       // Bus read data

	// Prescaler and wake wait
	reg  [11:0] pre_q;       // Prescaler count
	reg  [11:0] tick_q;      // Prescaler tap pulses
	reg  [11:0] ones;        // Low bits all ones
	reg         stby_q;      // Previous software standby
	reg  [15:0] wake_q;      // Wake wait remaining
	reg         wake_rdy_q;  // Wake wait done pulse

	// Pin and clock copies
	reg         pin_q;       // Pin level
	reg         oe_n_q;      // Pin enable, low drives
	reg         sys_q;       // System clock copy
	reg         sys_tick_q;  // System clock rise copy

	// Internal nets
	wire        run;         // Clock path running
	wire        evt;         // Corrected clock edge
	wire        lvl;         // Corrected clock level
	wire        fast;        // Correction in force
	wire        sys;         // Divider output
	wire        sys_rise;    // Divider rise pulse
	wire [1:0]  act;         // Ratio in force
	wire        acc;         // New bus access
	wire        wr;          // Byte lane 0 write
	wire        hit_div;     // Ratio register hit
	wire        hit_halt;    // Halt register hit
	wire        hit_stat;    // Status register hit
	wire        pin_en;      // Pin allowed to drive
	integer     k;

	// =============================================
	// Address decode

	// Word index compare
	function scd_hit;
		input [15:0] adr;
		input [15:0] idx;
		begin
			scd_hit = (adr == idx);
		end
	endfunction

	assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = acc & wb_we_i & wb_sel_i[0];
	assign hit_div  = scd_hit(wb_adr_i, `SCD_DIV_IDX);
	assign hit_halt = scd_hit(wb_adr_i, `SCD_HALT_IDX);
	assign hit_stat = scd_hit(wb_adr_i, `SCD_STAT_IDX);

	// Clock path halts in both standby modes
	assign run = ce_i & ~hw_standby_i & ~sw_standby_i;

	// =============================================
	// Clock path

	// Duty correction
	scd_duty_adjust u_duty (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (run),
		.osc_i  (osc_i),
		.lvl_o  (lvl),
		.evt_o  (evt),
		.fast_o (fast)
	);

	// Frequency divider on corrected edges
	scd_freq_divider u_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (run),
		.evt_i   (evt),
		.ratio_i (ratio_q),
		.sys_o   (sys),
		.rise_o  (sys_rise),
		.act_o   (act)
	);

	// =============================================
	// Register file

	// Ratio and pin stop registers
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ratio_q <= `SCD_RATIO_RST;
			clock_pin_stop_q <= `SCD_HALT_RST;
		end
		else if (ce_i)
		begin
			// Hardware standby reinitialises
			if (hw_standby_i)
				ratio_q <= `SCD_RATIO_RST;
			// Software standby changes nothing here
			else if (wr && hit_div)
				ratio_q <= wb_dat_i[1:0];
			if (wr && hit_halt)
				clock_pin_stop_q <= wb_dat_i[`SCD_CLOCK_PIN_STOP_BIT];
		end
	end

	// Bus answer one cycle after request
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			ack_q <= acc;
			dat_q <= 32'h0000_0000;
			if (acc && !wb_we_i)
			begin
				if (hit_div)
					// Reserved bits read as ones
					dat_q[7:0] <= `SCD_DIV_RSV |
						{6'h00, ratio_q};
				else if (hit_halt)
					dat_q[`SCD_CLOCK_PIN_STOP_BIT] <= clock_pin_stop_q;
				else if (hit_stat)
				begin
					// Block state for software
					dat_q[1:0] <= act;
					dat_q[2]   <= sys;
					dat_q[3]   <= lvl;
					dat_q[4]   <= fast;
					dat_q[5]   <= (wake_q != 16'h0000);
				end
				// Unmapped reads return zero
			end
		end
	end

	// =============================================
	// Prescaler

	// Carry chain of the count bits
	always @*
	begin
		ones = 12'h000;
		ones[0] = pre_q[0];
		for (k = 1; k < `SCD_PRE_W; k = k + 1)
			ones[k] = ones[k-1] & pre_q[k];
	end

	// Taps count system clock rises
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pre_q  <= 12'h000;
			tick_q <= 12'h000;
		end
		else if (ce_i)
		begin
			tick_q <= 12'h000;
			if (sys_rise && run)
			begin
				pre_q  <= pre_q + 12'h001;
				tick_q <= ones;
			end
		end
	end

	// =============================================
	// Software standby exit wait

	// Wait counted in system clock rises
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stby_q     <= 1'b0;
			wake_q     <= 16'h0000;
			wake_rdy_q <= 1'b0;
		end
		else if (ce_i)
		begin
			stby_q     <= sw_standby_i;
			wake_rdy_q <= 1'b0;
			// Exit from standby starts the wait
			if (stby_q && !sw_standby_i)
				wake_q <= WAKE_WAIT;
			else if (wake_q != 16'h0000 && sys_rise && run)
			begin
				wake_q <= wake_q - 16'h0001;
				if (wake_q == 16'h0001)
					wake_rdy_q <= 1'b1;
			end
		end
	end

	// =============================================
	// System clock pin

	assign pin_en = clk_out_mode_i & ~clock_pin_stop_q & ~hw_standby_i;

	// Pin level and enable
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_q      <= 1'b0;
			oe_n_q     <= 1'b1;
			sys_q      <= 1'b0;
			sys_tick_q <= 1'b0;
		end
		else if (ce_i)
		begin
			oe_n_q <= ~pin_en;
			// Pin held high in software standby while enabled
			if (!pin_en)
				pin_q <= 1'b0;
			else if (sw_standby_i)
				pin_q <= 1'b1;
			else
				pin_q <= sys;
			sys_q      <= sys;
			sys_tick_q <= sys_rise & run;
		end
	end

	// =============================================
	// Outputs

	assign wb_dat_o          = dat_q;
	assign wb_ack_o          = ack_q;
	assign sysclk_o          = sys_q;
	assign sys_tick_o        = sys_tick_q;
	assign presc_tick_o      = tick_q;
	assign wake_ready_o      = wake_rdy_q;
	assign sysclk_pin_o      = pin_q;
	assign sysclk_pin_oe_n_o = oe_n_q;
endmodule
`default_nettype wire

// file: scd_clock_divider_checker.sv
`include "scd_regs.vh"
`default_nettype none
// =============================================
// Port checker of the clock divider
module scd_clock_divider_checker (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [17:2] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Chip state and clocks
	input wire logic        hw_standby_i,
	input wire logic        clk_out_mode_i,
	input wire logic        sysclk_o,
	input wire logic        sys_tick_o,
	input wire logic        wake_ready_o,
	input wire logic        sysclk_pin_o,
	input wire logic        sysclk_pin_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i; // Taken request
	wire rd_div = req && !wb_we_i && wb_adr_i == `SCD_DIV_IDX; // Ratio read
	// =============================================
	// Assertions
	a_ack_latency: assert property (req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_rsv_ones: assert property (rd_div |=> wb_dat_o[31:2] == 30'h3f)
		else $error("reserved ratio bits wrong");
	a_tick_level: assert property (sys_tick_o |-> ##[0:2] sysclk_o)
		else $error("tick without system clock high");
	a_tick_single: assert property (sys_tick_o |=> !sys_tick_o)
		else $error("tick longer than one cycle");
	a_pin_off: assert property (hw_standby_i || !clk_out_mode_i
		|=> sysclk_pin_oe_n_o) else $error("pin driven when off");
	a_pin_low: assert property (sysclk_pin_oe_n_o
		&& $past(sysclk_pin_oe_n_o) |-> !sysclk_pin_o)
		else $error("pin level high when off");
	a_reset_clear: assert property (disable iff (1'b0) rst_i
		|=> !sysclk_o && !wb_ack_o && sysclk_pin_oe_n_o)
		else $error("outputs not cleared by reset");
	a_wake_single: assert property (wake_ready_o |=> !wake_ready_o)
		else $error("wake pulse too long");
	// Main scenarios
	c_div_read: cover property (rd_div ##1 wb_ack_o);
	c_wake: cover property (wake_ready_o);
	c_hw_off: cover property (hw_standby_i ##1 sysclk_pin_oe_n_o);
endmodule
`default_nettype wire

// file: scd_clock_divider_test.sv
`include "scd_regs.vh"
`default_nettype none
// =============================================
// Self-checking bench of the clock divider
module scd_clock_divider_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0; // Bench clock
	logic        rst_i = 1'b1; // Bench reset
	logic        cyc = 1'b0, we = 1'b0, hw = 1'b0, sw = 1'b0, mode = 1'b1;
	logic [15:0] adr = 16'h0; // Word index
	logic [31:0] dat = 32'h0; // Write data
	logic [7:0]  hi = 8'h01, lo = 8'h01; // Oscillator widths
	logic [31:0] exq[$]; // Expected read data
	wire  [31:0] rdat;
	wire  [11:0] presc;
	wire         osc, ack, sysclk, tick, wake, pin, oe_n;
	wire  [12:0] mon = {presc, tick}; // Pulse outputs by index
	int          fails = 0, tests_run = 0, n, seed = 32'hb5ef_e3c8;
	always #10 clk_i = !clk_i;
	scd_osc_model i_osc (.clk_i(clk_i), .hi_i(hi), .lo_i(lo), .osc_o(osc));
	scd_clock_divider #(.WAKE_WAIT(16'h0004)) i_dut (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .osc_i(osc), .hw_standby_i(hw),
		.sw_standby_i(sw), .clk_out_mode_i(mode), .sysclk_o(sysclk),
		.sys_tick_o(tick), .presc_tick_o(presc), .wake_ready_o(wake),
		.sysclk_pin_o(pin), .sysclk_pin_oe_n_o(oe_n));
	// Compare and count
	task check(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task complete_run;
		if (fails == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One classic cycle, held until ack
	task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		exq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// Cycles between two pulses of one output
	task gap(input int b, output int c);
		c = 0;
		@(posedge clk_i iff mon[b] === 1'b1);
		do begin @(posedge clk_i); c++; end while (mon[b] !== 1'b1);
	endtask
	// Width of one high phase of the system clock
	task high(output int c);
		c = 0;
		@(posedge clk_i iff sysclk === 1'b0);
		@(posedge clk_i iff sysclk === 1'b1);
		do begin @(posedge clk_i); c++; end while (sysclk === 1'b1);
	endtask
	// Read results taken off the queue at each read ack
	always @(posedge clk_i)
		if (ack === 1'b1 && !we)
			check("read data", rdat, exq.pop_front());
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`SCD_DIV_IDX, 32'h0000_00fc);
		// Every ratio code, fast source keeps the clock above its floor
		for (int r = 0; r < 4; r++)
		begin
			bus(1'b1, `SCD_DIV_IDX, $random(seed) & ~32'h3 | r);
			rd(`SCD_DIV_IDX, 32'h0000_00fc | r);
			gap(0, n);
			gap(0, n);
			check("sys period", n, 2 << r);
		end
		// Prescaler taps at divide by one
		bus(1'b1, `SCD_DIV_IDX, 32'h0);
		for (int k = 0; k < 12; k++)
		begin
			gap(k + 1, n);
			check("tap period", n, 2 << (k + 1));
		end
		// Duty: corrected when fast, raw when slow
		hi <= 8'h03;
		lo <= 8'h07;
		repeat (40) @(posedge clk_i);
		high(n);
		check("high width", n, 5);
		hi <= 8'h08;
		lo <= 8'h0c;
		repeat (60) @(posedge clk_i);
		high(n);
		check("high width", n, 8);
		hi <= 8'h01;
		lo <= 8'h01;
		// Software standby keeps ratio, wake wait scales with it
		for (int r = 1; r < 4; r += 2)
		begin
			bus(1'b1, `SCD_DIV_IDX, r);
			@(posedge clk_i);
			sw <= 1'b1;
			repeat (10) @(posedge clk_i);
			sw <= 1'b0;
			n = 0;
			do begin @(posedge clk_i); n++; end while (wake !== 1'b1 && n < 200);
			check("wake wait", n > 3 * (2 << r) && n <= 4 * (2 << r) + 8, 1);
			rd(`SCD_DIV_IDX, 32'h0000_00fc | r);
		end
		// Hardware standby reloads and turns the pin off
		@(posedge clk_i);
		hw <= 1'b1;
		repeat (4) @(posedge clk_i);
		check("pin enable", oe_n, 1);
		hw <= 1'b0;
		rd(`SCD_DIV_IDX, 32'h0000_00fc);
		// Pin enable over stop bit and mode
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, `SCD_HALT_IDX, i[0] ? 32'h0000_0080 : 32'h0);
			mode <= i[1];
			repeat (3) @(posedge clk_i);
			check("pin enable", oe_n, !(i[1] && !i[0]));
		end
		// Unmapped read, then reset in mid-run
		rd(16'h0000, 32'h0);
		bus(1'b1, `SCD_DIV_IDX, 32'h0000_0002);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`SCD_DIV_IDX, 32'h0000_00fc);
		complete_run;
	end
	// Watchdog
	initial
	begin
		#1_600_000;
		fails++;
		complete_run;
	end
endmodule
bind scd_clock_divider scd_clock_divider_checker i_chk (.clk_i, .rst_i,
	.ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .hw_standby_i, .clk_out_mode_i, .sysclk_o, .sys_tick_o,
	.wake_ready_o, .sysclk_pin_o, .sysclk_pin_oe_n_o);
`default_nettype wire

// file: scd_duty_adjust.v
`include "scd_regs.vh"
`default_nettype none
// =============================================
// Duty correction of the sampled oscillator
module scd_duty_adjust (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	// Oscillator level
	input  wire       osc_i,
	// Corrected clock
	output wire       lvl_o,
	output wire       evt_o,
	output wire       fast_o
);
	reg        osc_q;   // Previous oscillator sample
	reg  [7:0] cnt_q;   // Cycles since last rise
	reg  [7:0] per_q;   // Measured period
	reg        lvl_q;   // Corrected level
	reg        evt_q;   // Edge pulse of corrected level
	wire       rise;
	wire       fast;
	reg        lvl_d;
	wire [7:0] half;

	assign rise = osc_i & ~osc_q;
	// Period of ten cycles or less is 5 MHz or above
	assign fast = (per_q != 8'h00) &&
		(per_q <= `SCD_FAST_CYC);
	assign half = per_q >> 1;

	// Next level: regenerated half period or raw
	always @*
	begin
		if (rise)
			lvl_d = 1'b1;
		else if (fast)
			lvl_d = lvl_q & ((cnt_q + 8'h01) < half);
		else
			lvl_d = osc_i;
	end

	// Period measure and level register
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_q <= 1'b0;
			cnt_q <= 8'h00;
			per_q <= 8'h00;
			lvl_q <= 1'b0;
			evt_q <= 1'b0;
		end
		else if (ce_i)
		begin
			osc_q <= osc_i;
			if (rise)
			begin
				cnt_q <= 8'h00;
				// Saturate slow periods
				if (cnt_q != 8'hff)
					per_q <= cnt_q + 8'h01;
				else
					per_q <= 8'hff;
			end
			else if (cnt_q != 8'hff)
				cnt_q <= cnt_q + 8'h01;
			lvl_q <= lvl_d;
			evt_q <= lvl_d ^ lvl_q;
		end
	end

	assign lvl_o  = lvl_q;
	assign evt_o  = evt_q;
	assign fast_o = fast;
endmodule
`default_nettype wire

// file: scd_freq_divider.v
`include "scd_regs.vh"
`default_nettype none
// =============================================
// Divider of the corrected clock edges
module scd_freq_divider (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	// Corrected clock edge and ratio request
	input  wire       evt_i,
	input  wire [1:0] ratio_i,
	// System clock
	output wire       sys_o,
	output wire       rise_o,
	output wire [1:0] act_o
);
	reg  [2:0] cnt_q;   // Edges in current phase
	reg        sys_q;   // System clock level
	reg        rise_q;  // Pulse at system clock rise
	reg  [1:0] act_q;   // Ratio in force

	// Last edge index of one phase
	function [2:0] scd_last;
		input [1:0] r;
		begin
			case (r)
				`SCD_RATIO_D1: scd_last = 3'h0;
				`SCD_RATIO_D2: scd_last = 3'h1;
				`SCD_RATIO_D4: scd_last = 3'h3;
				default:       scd_last = 3'h7;
			endcase
		end
	endfunction

	// Toggle every N corrected edges
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= 3'h0;
			sys_q  <= 1'b0;
			rise_q <= 1'b0;
			act_q  <= `SCD_RATIO_RST;
		end
		else if (ce_i)
		begin
			rise_q <= 1'b0;
			if (evt_i)
			begin
				if (cnt_q >= scd_last(act_q))
				begin
					cnt_q <= 3'h0;
					sys_q <= ~sys_q;
					// New ratio only at a rising boundary
					if (!sys_q)
					begin
						act_q  <= ratio_i;
						rise_q <= 1'b1;
					end
				end
				else
					cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	assign sys_o  = sys_q;
	assign rise_o = rise_q;
	assign act_o  = act_q;
endmodule
`default_nettype wire

// file: scd_osc_model.sv
`default_nettype none
// =============================================
// Oscillator source with set high and low widths
module scd_osc_model (
	// Clock and phase widths in clock cycles
	input  wire logic       clk_i,
	input  wire logic [7:0] hi_i,
	input  wire logic [7:0] lo_i,
	// Oscillator level
	output var  logic       osc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q; // Cycles left in this phase
	initial
	begin
		osc_o = 1'b0;
		cnt_q = 8'h01;
	end
	// Count down the phase, flip the level when it runs out
	always @(posedge clk_i)
	begin
		if (cnt_q > 8'h01)
			cnt_q <= cnt_q - 8'h01;
		else
		begin
			osc_o <= !osc_o;
			cnt_q <= osc_o ? lo_i : hi_i;
		end
	end
endmodule
`default_nettype wire

// file: scd_regs.vh
`ifndef SCD_REGS_VH
`define SCD_REGS_VH
// =============================================
// Register indices (byte address = 4 x index)
`define SCD_DIV_IDX      16'hff5d
`define SCD_HALT_IDX     16'hff5e
`define SCD_STAT_IDX     16'hff60
// =============================================
// Field layout and reset values
`define SCD_DIV_RST      8'hfc
`define SCD_DIV_RSV      8'hfc
`define SCD_RATIO_RST    2'h0
`define SCD_RATIO_D1     2'h0
`define SCD_RATIO_D2     2'h1
`define SCD_RATIO_D4     2'h2
`define SCD_CLOCK_PIN_STOP_BIT    7
`define SCD_HALT_RST     1'b0
// =============================================
// Timing
`define SCD_CLK_MHZ      50
`define SCD_FAST_MHZ     5
// Clock cycles in one oscillator period at the correction threshold
`define SCD_FAST_CYC     8'h0a
`define SCD_PRE_W        12
`define SCD_WAKE_WAIT    16'h2000
`endif
